// ---- core/frc_pkg.sv ----
// Notes on behaviour
// - overvoltage stall enable slows deceleration while the bus rises too high.
// - overvoltage stall enable resets to 1 and blocks the regenerative brake.
// - current limit lowers frequency at threshold, restores it when load recovers.
// - current limit enable forces overcurrent trip prevention regardless of stall select.
// - stall threshold is percent of rated current, 1 to 200, for both uses.
// - stall threshold resets to 140 percent.
// - one shared threshold, independent of thermal and overload levels.
// - retry enabled: a trip resets itself and restarts after the waiting time.
// - class select 0 none, 1 short/overcurrent/heat, 2 overvoltage, 3 both.
// - retry attempt limit ranges 1 to 10.
// - successive retries are spaced by the restart waiting time.
// - alarm stays quiet during retries, asserts when retries are exhausted.
// - an unselected fault during retry raises the alarm and clears the count.
// - power removal clears the retry count.
// - more than 5 minutes without fault clears the retry count.
// - speed search starts after restart wait plus search wait.
// - start select 0 with run active starts once bus exceeds undervoltage.
// - start select resets to 1; run at power-on gives run-at-powerup trip.
// - start select 2 starts after bus is good and restart wait elapses.
// - start select 3 trips like 1; normal startup waits the restart time.
// - restart waiting time ranges 0.1 to 100.0 seconds.
package frc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_NS = 100_000_000;
  localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned TICKS_PER_S = 1_000_000_000 / TICK_NS;
  localparam int unsigned QUIET_S = 300;
  localparam int unsigned QUIET_TICKS = QUIET_S * TICKS_PER_S;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LEVEL = 8'h04;
  localparam logic [7:0] ADDR_WAIT = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_CMD = 8'h10;
  localparam int unsigned CTRL_OVS = 0;
  localparam int unsigned CTRL_CL = 1;
  localparam int unsigned CTRL_OCSEL = 2;
  localparam int unsigned CTRL_CLASS = 4;
  localparam int unsigned CTRL_POS = 6;
  localparam int unsigned CTRL_SRCH = 8;
  localparam int unsigned LEVEL_LIMIT = 8;
  localparam int unsigned WAIT_SEARCH = 16;
  localparam int unsigned STAT_ALARM = 4;
  localparam int unsigned STAT_OPTRIP = 5;
  localparam int unsigned STAT_RUN = 6;
  localparam logic [9:0] PCT_MIN = 10'h001;
  localparam logic [9:0] PCT_MAX = 10'h0C8;
  localparam logic [7:0] PCT_RESET = 8'h8C;
  localparam logic [9:0] LIMIT_MIN = 10'h001;
  localparam logic [9:0] LIMIT_MAX = 10'h00A;
  localparam logic [3:0] LIMIT_RESET = 4'h1;
  localparam logic [9:0] WAIT_MIN = 10'h001;
  localparam logic [9:0] WAIT_MAX = 10'h3E8;
  localparam logic [9:0] WAIT_RESET = 10'h00A;
  localparam logic [1:0] POS_RESET = 2'h1;
  localparam logic [1:0] POS_RUN = 2'h0;
  localparam logic [1:0] POS_STOP = 2'h1;
  localparam logic [1:0] POS_WAIT = 2'h2;
  localparam logic [1:0] POS_STOP_WAIT = 2'h3;
  localparam logic [1:0] SEL_BOTH = 2'h1;
  localparam logic [1:0] SEL_PREV_ONLY = 2'h2;
  localparam logic [1:0] SEL_STALL_ONLY = 2'h3;
  localparam logic [1:0] CLASS_OFF = 2'h0;
  localparam logic [1:0] CLASS_CURRENT = 2'h1;
  localparam logic [1:0] CLASS_VOLTAGE = 2'h2;
  localparam logic [1:0] CLASS_ALL = 2'h3;
  typedef enum logic [2:0] {
    S_POWERUP, S_POWER_WAIT, S_READY, S_RUN, S_RETRY_WAIT, S_SEARCH_WAIT, S_TRIPPED, S_OP_TRIP
  } frc_state_e;
endpackage

// ---- core/frc_fault_retry_start.sv ----
`timescale 1ns/1ps
module frc_fault_retry_start #(
  parameter int unsigned TICK_CYCLES = frc_pkg::TICK_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_bus_above_uv,
  input wire logic i_run,
  input wire logic i_fault_reset,
  input wire logic i_decelerating,
  input wire logic i_bus_high,
  input wire logic i_brake_request,
  input wire logic [5:0] i_short_circuit_fault,
  input wire logic [2:0] i_overcurrent_fault,
  input wire logic i_heatsink_fault,
  input wire logic [2:0] i_overvoltage_fault,
  input wire logic i_other_fault,
  input wire logic [8:0] i_current_percent,
  output logic o_run_enable,
  output logic o_fault_alarm,
  output logic o_run_at_powerup_trip,
  output logic o_decel_hold,
  output logic o_brake_enable,
  output logic o_freq_foldback,
  output logic o_accel_extend,
  output logic o_trip_prevent,
  output logic o_speed_search
);
  import frc_pkg::*;

  localparam int PIN_W = 20;
  localparam int PRE_W = $clog2(TICK_CYCLES);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);
  localparam logic [11:0] QUIET_LAST = 12'(QUIET_TICKS - 1);

  function automatic logic [9:0] clamp(input logic [9:0] v, input logic [9:0] lo,
                                       input logic [9:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic stall_on(input logic [1:0] sel);
    stall_on = (sel == SEL_BOTH) || (sel == SEL_STALL_ONLY);
  endfunction

  function automatic logic prevent_on(input logic [1:0] sel, input logic cl);
    prevent_on = cl || (sel == SEL_BOTH) || (sel == SEL_PREV_ONLY);
  endfunction

  // pin synchroniser, two stages
  logic [PIN_W-1:0] sync1_reg, sync2_reg;
  wire [PIN_W-1:0] pins = {i_bus_above_uv, i_run, i_fault_reset, i_decelerating, i_bus_high,
                           i_brake_request, i_short_circuit_fault, i_overcurrent_fault,
                           i_heatsink_fault, i_overvoltage_fault, i_other_fault};
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
    end
  end
  wire bus_ok = sync2_reg[19];
  wire run = sync2_reg[18];
  wire fault_reset = sync2_reg[17];
  wire decel = sync2_reg[16];
  wire bus_high = sync2_reg[15];
  wire brake_req = sync2_reg[14];
  wire current_grp = |sync2_reg[13:4];
  wire voltage_grp = |sync2_reg[3:1];
  wire other_grp = sync2_reg[0];

  // configuration registers
  logic ovs_en_reg, cl_en_reg, srch_sel_reg;
  logic [1:0] ocsel_reg, class_reg, pos_reg;
  logic [7:0] pct_reg;
  logic [3:0] limit_reg;
  logic [9:0] restart_wait_reg, search_wait_reg;
  logic pready_reg, pslverr_reg;
  logic [31:0] prdata_reg;
  logic reset_cmd_reg;

  frc_state_e state_reg, state_next;
  logic [3:0] count_reg, count_next;
  logic [9:0] wait_reg, wait_val;
  logic wait_load;
  logic [PRE_W-1:0] pre_reg;
  logic [11:0] quiet_reg;

  wire mapped = (i_paddr == ADDR_CTRL) || (i_paddr == ADDR_LEVEL) || (i_paddr == ADDR_WAIT) ||
                (i_paddr == ADDR_STATUS) || (i_paddr == ADDR_CMD);
  wire access = i_psel && i_penable;
  wire wr_fire = access && pready_reg && i_pwrite && mapped;
  wire [31:0] ctrl_word = {23'h00_0000, srch_sel_reg, pos_reg, class_reg, ocsel_reg,
                           cl_en_reg, ovs_en_reg};
  wire [31:0] level_word = {20'h0_0000, limit_reg, pct_reg};
  wire [31:0] wait_word = {6'h00, search_wait_reg, 6'h00, restart_wait_reg};
  wire [31:0] status_word = {25'h000_0000, o_run_enable, o_run_at_powerup_trip, o_fault_alarm,
                             count_reg};
  wire [31:0] rd_mux = (i_paddr == ADDR_CTRL) ? ctrl_word :
                       (i_paddr == ADDR_LEVEL) ? level_word :
                       (i_paddr == ADDR_WAIT) ? wait_word :
                       (i_paddr == ADDR_STATUS) ? status_word : 32'h0000_0000;

  // apb slave, one wait state
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= access && !pready_reg;
      pslverr_reg <= access && !pready_reg && !mapped;
      prdata_reg <= (access && !pready_reg && !i_pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ovs_en_reg <= 1'b1;
      cl_en_reg <= 1'b0;
      ocsel_reg <= 2'h0;
      class_reg <= CLASS_OFF;
      pos_reg <= POS_RESET;
      srch_sel_reg <= 1'b0;
      pct_reg <= PCT_RESET;
      limit_reg <= LIMIT_RESET;
      restart_wait_reg <= WAIT_RESET;
      search_wait_reg <= WAIT_RESET;
      reset_cmd_reg <= 1'b0;
    end else begin
      reset_cmd_reg <= wr_fire && (i_paddr == ADDR_CMD) && i_pwdata[0];
      if (wr_fire && (i_paddr == ADDR_CTRL)) begin
        ovs_en_reg <= i_pwdata[CTRL_OVS];
        cl_en_reg <= i_pwdata[CTRL_CL];
        ocsel_reg <= i_pwdata[CTRL_OCSEL +: 2];
        class_reg <= i_pwdata[CTRL_CLASS +: 2];
        pos_reg <= i_pwdata[CTRL_POS +: 2];
        srch_sel_reg <= i_pwdata[CTRL_SRCH];
      end
      if (wr_fire && (i_paddr == ADDR_LEVEL)) begin
        pct_reg <= 8'(clamp({2'b00, i_pwdata[7:0]}, PCT_MIN, PCT_MAX));
        limit_reg <= 4'(clamp({6'h00, i_pwdata[LEVEL_LIMIT +: 4]}, LIMIT_MIN, LIMIT_MAX));
      end
      if (wr_fire && (i_paddr == ADDR_WAIT)) begin
        restart_wait_reg <= clamp(i_pwdata[9:0], WAIT_MIN, WAIT_MAX);
        search_wait_reg <= clamp(i_pwdata[WAIT_SEARCH +: 10], WAIT_MIN, WAIT_MAX);
      end
    end
  end

  // protection outputs
  wire at_limit = i_current_percent >= {1'b0, pct_reg};
  wire fault_any = current_grp || voltage_grp || other_grp;
  wire current_sel = (class_reg == CLASS_CURRENT) || (class_reg == CLASS_ALL);
  wire voltage_sel = (class_reg == CLASS_VOLTAGE) || (class_reg == CLASS_ALL);
  wire unselected = other_grp || (current_grp && !current_sel) ||
                    (voltage_grp && !voltage_sel);
  wire class_hit = !unselected;
  wire tick = (pre_reg == PRE_LAST);
  wire wait_done = (wait_reg == 10'h000);
  wire quiet_done = tick && (quiet_reg == QUIET_LAST);
  wire clear_req = fault_reset || reset_cmd_reg;
  wire pos_trips = (pos_reg == POS_STOP) || (pos_reg == POS_STOP_WAIT);
  wire pos_waits = (pos_reg == POS_WAIT) || (pos_reg == POS_STOP_WAIT);

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    wait_load = 1'b0;
    wait_val = restart_wait_reg;
    unique case (state_reg)
      S_POWERUP: begin
        if (bus_ok) begin
          if (run && pos_trips) begin
            state_next = S_OP_TRIP;
          end else if (pos_waits) begin
            state_next = S_POWER_WAIT;
            wait_load = 1'b1;
          end else begin
            state_next = run ? S_RUN : S_READY;
          end
        end
      end
      S_POWER_WAIT: begin
        if (wait_done) begin
          state_next = run ? S_RUN : S_READY;
        end
      end
      S_READY: begin
        if (run) begin
          state_next = S_RUN;
        end
      end
      S_RUN: begin
        if (fault_any) begin
          if (class_hit && (class_reg != CLASS_OFF) && (count_reg < limit_reg)) begin
            count_next = count_reg + 4'h1;
            state_next = S_RETRY_WAIT;
            wait_load = 1'b1;
          end else begin
            state_next = S_TRIPPED;
            if (!class_hit) begin
              count_next = 4'h0;
            end
          end
        end else if (!run) begin
          state_next = S_READY;
        end
      end
      S_RETRY_WAIT, S_SEARCH_WAIT: begin
        if (unselected) begin
          state_next = S_TRIPPED;
          count_next = 4'h0;
        end else if (wait_done && state_reg == S_RETRY_WAIT && srch_sel_reg) begin
          state_next = S_SEARCH_WAIT;
          wait_load = 1'b1;
          wait_val = search_wait_reg;
        end else if (wait_done) begin
          state_next = S_RUN;
        end
      end
      S_TRIPPED: begin
        if (clear_req) begin
          state_next = S_READY;
        end
      end
      S_OP_TRIP: begin
        if (clear_req && !run) begin
          state_next = S_READY;
        end
      end
    endcase
    if (quiet_done) begin
      count_next = 4'h0;
    end
    if (!bus_ok) begin
      count_next = 4'h0;
      state_next = S_POWERUP;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= S_POWERUP;
      count_reg <= 4'h0;
      wait_reg <= 10'h000;
      pre_reg <= '0;
      quiet_reg <= 12'h000;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      pre_reg <= (tick || wait_load) ? '0 : pre_reg + 1'b1;
      wait_reg <= wait_load ? wait_val : ((tick && !wait_done) ? wait_reg - 10'h001 : wait_reg);
      quiet_reg <= (fault_any || quiet_done) ? 12'h000 : (tick ? quiet_reg + 12'h001 : quiet_reg);
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_run_enable <= 1'b0;
      o_fault_alarm <= 1'b0;
      o_run_at_powerup_trip <= 1'b0;
      o_decel_hold <= 1'b0;
      o_brake_enable <= 1'b0;
      o_freq_foldback <= 1'b0;
      o_accel_extend <= 1'b0;
      o_trip_prevent <= 1'b0;
      o_speed_search <= 1'b0;
    end else begin
      o_run_enable <= (state_next == S_RUN);
      o_fault_alarm <= (state_next == S_TRIPPED) || (state_next == S_OP_TRIP);
      o_run_at_powerup_trip <= (state_next == S_OP_TRIP);
      o_decel_hold <= ovs_en_reg && decel && bus_high;
      o_brake_enable <= !ovs_en_reg && brake_req;
      o_freq_foldback <= cl_en_reg && at_limit;
      o_accel_extend <= stall_on(ocsel_reg) && at_limit;
      o_trip_prevent <= prevent_on(ocsel_reg, cl_en_reg);
      o_speed_search <= (state_reg == S_SEARCH_WAIT) && wait_done && !unselected;
    end
  end

  assign o_prdata = prdata_reg;
  assign o_pready = pready_reg;
  assign o_pslverr = pslverr_reg;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);

  a_ovs_hold_cause: assert property (o_decel_hold |-> $past(ovs_en_reg && decel))
    else $error("decel hold without stall enable");
  a_brake_blocked: assert property (o_brake_enable |-> !$past(ovs_en_reg))
    else $error("brake active while stall enabled");
  a_foldback_level: assert property (cl_en_reg && at_limit |=> o_freq_foldback)
    else $error("foldback missed at threshold");
  a_prevent_forced: assert property (cl_en_reg |=> o_trip_prevent)
    else $error("trip prevention off with current limit");
  a_threshold_range: assert property (pct_reg >= PCT_MIN[7:0] && pct_reg <= PCT_MAX[7:0])
    else $error("threshold out of range");
  a_count_bounded: assert property (count_reg > $past(count_reg) |->
    count_reg <= $past(limit_reg))
    else $error("retry count above limit");
  a_retry_quiet: assert property (state_reg == S_RETRY_WAIT |=>
    !o_fault_alarm || state_reg == S_TRIPPED || state_reg == S_POWERUP)
    else $error("alarm during retry");
  a_unselected_clear: assert property (state_reg == S_RETRY_WAIT && other_grp && bus_ok |=>
    state_reg == S_TRIPPED && count_reg == 4'h0 ##0 o_fault_alarm)
    else $error("unselected fault not handled");
  a_retry_spacing: assert property ($rose(state_reg == S_RETRY_WAIT) |->
    wait_reg == restart_wait_reg)
    else $error("retry wait not loaded");
  a_op_trip_entry: assert property (state_reg == S_POWERUP && bus_ok && run && pos_trips
    |=> state_reg == S_OP_TRIP ##1 o_run_at_powerup_trip && o_fault_alarm)
    else $error("run at powerup trip missed");
  a_power_loss_clear: assert property (!bus_ok |=> count_reg == 4'h0)
    else $error("count kept after power loss");
  a_quiet_clear: assert property (quiet_done |=> count_reg == 4'h0)
    else $error("count kept after quiet time");
  a_search_after_wait: assert property (o_speed_search |->
    $past(state_reg == S_SEARCH_WAIT && wait_done))
    else $error("speed search before both waits");
  a_start_direct: assert property (state_reg == S_POWERUP && bus_ok && run &&
    pos_reg == POS_RUN |=> o_run_enable)
    else $error("direct start missed");
  a_start_delayed: assert property (state_reg == S_POWERUP && bus_ok && pos_waits &&
    !(run && pos_trips) |=> state_reg == S_POWER_WAIT && !o_run_enable)
    else $error("delayed start skipped the wait");
  a_retry_entry: assert property (state_reg == S_RUN && bus_ok && fault_any && class_hit &&
    class_reg != CLASS_OFF && count_reg < limit_reg |=>
    state_reg == S_RETRY_WAIT && !o_fault_alarm)
    else $error("retry not started");
  a_limit_latch: assert property (state_reg == S_RUN && bus_ok && fault_any &&
    count_reg >= limit_reg |=> state_reg == S_TRIPPED && o_fault_alarm)
    else $error("fault past limit not latched");
  a_class_off: assert property (state_reg == S_RUN && bus_ok && fault_any &&
    class_reg == CLASS_OFF |=> state_reg == S_TRIPPED)
    else $error("retry with class off");
endmodule

// ---- sim/frc_partner.sv ----
`timescale 1ns/1ps
module frc_partner (
  input wire logic i_clock,
  output logic o_bus_above_uv,
  output logic o_run,
  output logic o_fault_reset,
  output logic [5:0] o_short_circuit_fault,
  output logic [2:0] o_overcurrent_fault,
  output logic o_heatsink_fault,
  output logic [2:0] o_overvoltage_fault,
  output logic o_other_fault
);
  int nf = 0;
  initial begin
    {o_bus_above_uv, o_run, o_fault_reset} = 3'h0;
    {o_short_circuit_fault, o_overcurrent_fault} = 9'h000;
    {o_heatsink_fault, o_overvoltage_fault, o_other_fault} = 5'h00;
  end
  task automatic pins(input logic bus, input logic run);
    @(posedge i_clock);
    o_bus_above_uv <= bus;
    o_run <= run;
  endtask
  // kind: 0 short, 1 overcurrent, 2 heatsink, 3 overvoltage, 4 never retried
  task automatic fault(input int kind);
    nf++;
    @(posedge i_clock);
    case (kind)
      0: o_short_circuit_fault <= 6'h01 << (nf % 6);
      1: o_overcurrent_fault <= 3'h1 << (nf % 3);
      2: o_heatsink_fault <= 1'b1;
      3: o_overvoltage_fault <= 3'h1 << (nf % 3);
      default: o_other_fault <= 1'b1;
    endcase
    repeat (4) @(posedge i_clock);
    {o_short_circuit_fault, o_overcurrent_fault} <= 9'h000;
    {o_heatsink_fault, o_overvoltage_fault, o_other_fault} <= 5'h00;
  endtask
  // drop run, pulse reset, then run again
  task automatic clear_trip();
    pins(o_bus_above_uv, 1'b0);
    repeat (4) @(posedge i_clock);
    o_fault_reset <= 1'b1;
    repeat (4) @(posedge i_clock);
    o_fault_reset <= 1'b0;
    repeat (4) @(posedge i_clock);
    o_run <= 1'b1;
  endtask
endmodule

// ---- sim/tb_fault_retry_start_control.sv ----
`timescale 1ns/1ps
module tb_fault_retry_start_control;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic err;} frc_row_s;
  localparam int SS = 7, RE = 6, AL = 5, PT = 4, DH = 3, BE = 2, FB = 1, TP = 0;
  logic clk = 1'b0;
  logic rst_n, psel, pen, pwr, dec, bhi, brk, rt, er;
  logic [7:0] padr;
  logic [31:0] pwd, rd, prdata;
  logic [8:0] cur;
  logic pready, pslverr, acc, bus, run, frst, hs, oth;
  logic [5:0] sc;
  logic [2:0] oc, ov;
  wire [7:0] outs;
  int miscompares = 0;
  int checks = 0;
  int wn;
  frc_row_s rows [17] = '{
    '{1'b0, 8'h00, '0, 32'h0000_0041, 1'b0},
    '{1'b0, 8'h04, '0, 32'h0000_018C, 1'b0},
    '{1'b0, 8'h08, '0, 32'h000A_000A, 1'b0},
    '{1'b0, 8'h14, '0, 32'h0000_0000, 1'b1},
    '{1'b1, 8'h14, 32'hFFFF_FFFF, '0, 1'b1},
    '{1'b0, 8'h0C, '0, 32'h0000_0000, 1'b0},
    '{1'b1, 8'h04, 32'h0000_0000, '0, 1'b0},
    '{1'b0, 8'h04, '0, 32'h0000_0101, 1'b0},
    '{1'b1, 8'h04, 32'h0000_0FFF, '0, 1'b0},
    '{1'b0, 8'h04, '0, 32'h0000_0AC8, 1'b0},
    '{1'b1, 8'h08, 32'h07FF_07FF, '0, 1'b0},
    '{1'b0, 8'h08, '0, 32'h03E8_03E8, 1'b0},
    '{1'b1, 8'h08, 32'h0000_0000, '0, 1'b0},
    '{1'b0, 8'h08, '0, 32'h0001_0001, 1'b0},
    '{1'b1, 8'h08, 32'h0001_0002, '0, 1'b0},
    '{1'b1, 8'h04, 32'h0000_0A64, '0, 1'b0},
    '{1'b0, 8'h04, '0, 32'h0000_0A64, 1'b0}
  };
  always #5 clk = ~clk;
  frc_partner pm (.i_clock(clk), .o_bus_above_uv(bus), .o_run(run), .o_fault_reset(frst),
    .o_short_circuit_fault(sc), .o_overcurrent_fault(oc), .o_heatsink_fault(hs),
    .o_overvoltage_fault(ov), .o_other_fault(oth));
  frc_fault_retry_start #(.TICK_CYCLES(20)) uut (
    .i_clock(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(padr), .i_pwdata(pwd), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_bus_above_uv(bus), .i_run(run), .i_fault_reset(frst),
    .i_decelerating(dec), .i_bus_high(bhi), .i_brake_request(brk),
    .i_short_circuit_fault(sc), .i_overcurrent_fault(oc), .i_heatsink_fault(hs),
    .i_overvoltage_fault(ov), .i_other_fault(oth), .i_current_percent(cur),
    .o_run_enable(outs[RE]), .o_fault_alarm(outs[AL]), .o_run_at_powerup_trip(outs[PT]),
    .o_decel_hold(outs[DH]), .o_brake_enable(outs[BE]), .o_freq_foldback(outs[FB]),
    .o_accel_extend(acc), .o_trip_prevent(outs[TP]), .o_speed_search(outs[SS]));
  task automatic finish_test();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rng(input int lo, input int hi);
    chk({31'h0000_0000, wn >= lo && wn <= hi}, 32'h0000_0001);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (pready !== 1'b1) begin
      miscompares++;
      $display("BAD %0t no bus answer", $time);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, '0);
    chk(rd, e);
  endtask
  task automatic wait_sig(input int i, input logic v, input int mx);
    wn = 0;
    while (outs[i] !== v && wn < mx) begin
      @(posedge clk);
      wn++;
    end
    if (outs[i] !== v) begin
      miscompares++;
      $display("BAD %0t wait on output %0d", $time, i);
    end
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    finish_test();
  end
  initial begin
    rst_n = 1'b0;
    {psel, pen, pwr, dec, bhi, brk} = 6'h00;
    {padr, pwd, cur} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk(er, rows[i].err);
      if (!rows[i].w) chk(rd, rows[i].e);
    end
    // run held while the bus comes up
    pm.pins(1'b0, 1'b1);
    pm.pins(1'b1, 1'b1);
    wait_sig(PT, 1'b1, 20);
    chk(outs[AL], 1'b1);
    chk(outs[RE], 1'b0);
    pm.clear_trip();
    wait_sig(RE, 1'b1, 40);
    chk(outs[PT], 1'b0);
    {dec, bhi, brk} <= 3'h4;
    repeat (6) @(posedge clk);
    chk(outs[DH], 1'b0);
    {dec, bhi, brk} <= 3'h7;
    repeat (6) @(posedge clk);
    chk(outs[DH], 1'b1);
    chk(outs[BE], 1'b0);
    apb(1'b1, 8'h00, 32'h0000_0040);
    repeat (6) @(posedge clk);
    chk(outs[DH], 1'b0);
    chk(outs[BE], 1'b1);
    {dec, bhi, brk} <= 3'h6;
    repeat (6) @(posedge clk);
    chk(outs[BE], 1'b0);
    {dec, bhi, brk} <= 3'h0;
    apb(1'b1, 8'h00, 32'h0000_0042);
    cur <= 9'h064;
    repeat (4) @(posedge clk);
    chk(outs[FB], 1'b1);
    chk(outs[TP], 1'b1);
    cur <= 9'h063;
    repeat (4) @(posedge clk);
    chk(outs[FB], 1'b0);
    apb(1'b1, 8'h00, 32'h0000_0040);
    repeat (3) @(posedge clk);
    chk(outs[TP], 1'b0);
    cur <= 9'h064;
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, 8'h00, 32'h0000_0040 + 32'(s * 4));
      repeat (3) @(posedge clk);
      chk(acc, s[0]);
      chk(outs[TP], s == 1 || s == 2);
    end
    cur <= 9'h000;
    // every class against every fault kind
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 5; k++) begin
        apb(1'b1, 8'h00, 32'h0000_0040 + 32'(c * 16));
        pm.fault(k);
        repeat (4) @(posedge clk);
        rt = (k < 3) ? c[0] : (k == 3) ? c[1] : 1'b0;
        chk(outs[AL], !rt);
        if (!rt) pm.clear_trip();
        wait_sig(RE, 1'b1, 60);
      end
    end
    apb(1'b1, 8'h00, 32'h0000_0050);
    pm.fault(1);
    pm.fault(4);
    wait_sig(AL, 1'b1, 10);
    rchk(8'h0C, 32'h0000_0010);
    pm.clear_trip();
    wait_sig(RE, 1'b1, 40);
    pm.fault(1);
    pm.fault(3);
    wait_sig(AL, 1'b1, 10);
    rchk(8'h0C, 32'h0000_0010);
    pm.clear_trip();
    wait_sig(RE, 1'b1, 40);
    apb(1'b1, 8'h04, 32'h0000_0264);
    for (int r = 1; r <= 3; r++) begin
      pm.fault(1);
      repeat (2) @(posedge clk);
      chk(outs[RE], 1'b0);
      chk(outs[AL], r > 2);
      if (r < 3) begin
        wait_sig(RE, 1'b1, 60);
        rng(30, 48);
        rchk(8'h0C, 32'h0000_0040 + r);
      end
    end
    repeat (60) @(posedge clk);
    chk(outs[RE], 1'b0);
    repeat (58900) @(posedge clk);
    rchk(8'h0C, 32'h0000_0012);
    repeat (1300) @(posedge clk);
    rchk(8'h0C, 32'h0000_0010);
    pm.clear_trip();
    wait_sig(RE, 1'b1, 40);
    pm.fault(1);
    wait_sig(RE, 1'b1, 60);
    pm.pins(1'b0, 1'b1);
    repeat (6) @(posedge clk);
    rchk(8'h0C, 32'h0000_0000);
    apb(1'b1, 8'h00, 32'h0000_0010);
    pm.pins(1'b1, 1'b1);
    wait_sig(RE, 1'b1, 15);
    rng(1, 8);
    pm.pins(1'b0, 1'b1);
    apb(1'b1, 8'h00, 32'h0000_0090);
    pm.pins(1'b1, 1'b1);
    wait_sig(RE, 1'b1, 80);
    rng(35, 50);
    pm.pins(1'b0, 1'b1);
    apb(1'b1, 8'h00, 32'h0000_00D0);
    pm.pins(1'b1, 1'b1);
    wait_sig(PT, 1'b1, 20);
    rng(1, 8);
    pm.clear_trip();
    pm.pins(1'b0, 1'b0);
    repeat (6) @(posedge clk);
    pm.pins(1'b1, 1'b0);
    repeat (6) @(posedge clk);
    pm.pins(1'b1, 1'b1);
    wait_sig(RE, 1'b1, 80);
    rng(22, 45);
    apb(1'b1, 8'h00, 32'h0000_0150);
    pm.fault(1);
    wait_sig(SS, 1'b1, 90);
    rng(50, 64);
    wait_sig(RE, 1'b1, 10);
    finish_test();
  end
endmodule
